// file: bench/dts_master_model.sv
// Bus master model that drives the slave's strobes, address and data.
`timescale 1ns/10ps
`default_nettype none
module dts_master_model (
  input  wire logic        ref_clk,
  input  wire logic        busGrant,
  input  wire logic        dtackOeN,
  input  wire logic        berrOeN,
  input  wire logic [31:0] rdata,
  output logic             bbsyN,
  output logic             asN,
  output logic             ds0N,
  output logic             ds1N,
  output logic             writeN,
  output logic             lwordN,
  output logic [30:0]      addr,
  output logic [31:0]      wdata
);
  initial {bbsyN, asN, ds0N, ds1N, writeN, lwordN, addr, wdata} = '1;
  // Kinds: 0 even byte, 1 odd byte, 2 double, 3 quad, 4 bad quad, 5 address only.
  task automatic cyc(input logic [30:0] a, input int k, input bit w, input logic [31:0] d,
                     input bit ovl, output int rsp, output logic [31:0] got);
    int n;
    bit late;
    // bus owned first; grant awaited only if busy not already held.
    for (n = 0; bbsyN && n < 40; n++) begin
      @(posedge ref_clk);
      if (busGrant) bbsyN <= 1'b0;
    end
    // A wait that runs out is handed back to the caller as response code 3.
    late = (n == 40);
    // wait until the slave lets go.
    for (n = 0; !(dtackOeN === 1'b1 && berrOeN === 1'b1) && n < 40; n++) @(posedge ref_clk);
    if (n == 40) late = 1'b1;
    @(posedge ref_clk);
    if (!asN && (addr !== a || lwordN !== !(k == 3 || k == 4))) begin
      asN <= 1'b1;
      @(posedge ref_clk);
    end
    addr <= a;
    lwordN <= !(k == 3 || k == 4);
    writeN <= !w;
    wdata <= d;
    asN <= 1'b0;
    @(posedge ref_clk);
    ds1N <= k == 1 || k == 5;
    ds0N <= k != 1;
    // second strobe falls a cycle late.
    if (k >= 2 && k <= 4) begin
      @(posedge ref_clk);
      ds0N <= 1'b0;
    end
    rsp = 0;
    for (n = 0; n < 20 && rsp == 0; n++) begin
      @(posedge ref_clk);
      rsp = dtackOeN === 1'b0 ? 1 : berrOeN === 1'b0 ? 2 : 0;
      got = rdata;
    end
    if (late) rsp = 3;
    @(posedge ref_clk);
    asN <= 1'b1;
    // next address strobe while data strobes are still low.
    if (ovl) begin
      @(posedge ref_clk);
      asN <= 1'b0;
    end
    @(posedge ref_clk);
    ds0N <= 1'b1;
    @(posedge ref_clk);
    ds1N <= 1'b1;
  endtask
  // busy released only after the address strobe is high.
  task automatic release_bus;
    @(posedge ref_clk);
    asN <= 1'b1;
    @(posedge ref_clk);
    bbsyN <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: bench/dts_slave_monitor.sv
// Port checker for the data-transfer-bus slave.
`timescale 1ns/10ps
`default_nettype none
module dts_slave_monitor #(
  parameter int                         MEM_IDX_W = 8,
  parameter logic [dts_pkg::ADDR_W-1:0] BASE      = 31'h0000_0000
) (
  input wire logic                       ref_clk,
  input wire logic                       rstn,
  input wire logic [dts_pkg::ADDR_W-1:0] addrIn,
  input wire logic                       ds0N,
  input wire logic                       ds1N,
  input wire logic                       dataOeN,
  input wire logic                       dtackOut,
  input wire logic                       dtackOeN,
  input wire logic                       berrOut,
  input wire logic                       berrOeN
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Both strobes high, and the address falls in this slave's window.
  logic dsIdle;
  logic hit;
  assign dsIdle = ds0N & ds1N;
  assign hit = addrIn[30:MEM_IDX_W+1] == BASE[30:MEM_IDX_W+1];
  sequence dsFall; $past(dsIdle) && !dsIdle; endsequence
  sequence dsHeld; (!dsIdle && hit)[*8]; endsequence
  sequence missHeld; (!dsIdle && !hit)[*8]; endsequence
  AST_ACK_ON_FALL: assert property ((dsFall and hit) ##1 dsHeld |-> !(dtackOeN && berrOeN))
    else $error("no answer after strobe fall");
  AST_IDLE_QUIET: assert property (dsIdle[*4] |-> dtackOeN && berrOeN && dataOeN)
    else $error("drive kept without strobes");
  AST_ACK_HOLD: assert property (!dtackOeN && !dsIdle |=> !dtackOeN)
    else $error("acknowledge dropped early");
  AST_ONE_ANSWER: assert property (!(!dtackOeN && !berrOeN))
    else $error("acknowledge and bus error together");
  AST_ACK_LEVEL: assert property (!dtackOeN |-> !dtackOut)
    else $error("acknowledge driven high");
  AST_DATA_WITH_ACK: assert property ($fell(dataOeN) |-> !dtackOeN || !berrOeN)
    else $error("data driven without answer");
  AST_MISS_SILENT: assert property ((dsFall and !hit) ##1 missHeld |-> dtackOeN && berrOeN)
    else $error("answer outside window");
  AST_BERR_LEVEL: assert property (!berrOeN |-> !berrOut)
    else $error("bus error driven high");
endmodule
bind dts_slave dts_slave_monitor #(.MEM_IDX_W(MEM_IDX_W), .BASE(BASE)) dts_slave_monitor_i (
  .ref_clk(ref_clk), .rstn(rstn), .addrIn(addrIn), .ds0N(ds0N), .ds1N(ds1N),
  .dataOeN(dataOeN), .dtackOut(dtackOut), .dtackOeN(dtackOeN), .berrOut(berrOut),
  .berrOeN(berrOeN));
`default_nettype wire

// file: bench/tb_dts_slave.sv
// Self-checking bench for the data-transfer-bus slave.
`timescale 1ns/10ps
`default_nettype none
module tb_dts_slave;
  logic        ref_clk  = 1'b0;
  logic        rstn     = 1'b0;
  logic        busGrant = 1'b1;
  logic [5:0]  am       = 6'h00;
  logic [30:0] addr;
  logic [31:0] wdata, sOut, dataBus;
  logic        asN, ds0N, ds1N, writeN, lwordN, bbsyN, dataOeN, dtackOeN, berrOeN;
  logic [31:0] mem [int];
  int          error_cnt  = 0;
  int          num_checks = 0;
  logic        accessPulse, accessWrite;
  int          pulseCnt   = 0;
  int          ackCnt     = 0;
  // Released data lines show the inverse of the last value.
  assign dataBus = !dataOeN ? sOut : (!writeN ? wdata : ~wdata);
  initial forever #2 ref_clk = ~ref_clk;
  // Count the completed-transfer pulses that the slave reports.
  always @(posedge ref_clk) if (accessPulse === 1'b1) pulseCnt++;
  dts_slave dts_slave_i (.ref_clk(ref_clk), .rstn(rstn), .addrIn(addr), .amIn(am),
    .lwordN(lwordN), .iackN(1'b1), .asN(asN), .ds0N(ds0N), .ds1N(ds1N), .writeN(writeN),
    .dataIn(dataBus), .dataOut(sOut), .dataOeN(dataOeN), .dtackOut(), .dtackOeN(dtackOeN),
    .berrOut(), .berrOeN(berrOeN), .accessPulse(accessPulse), .accessWrite(accessWrite));
  dts_master_model dts_master_model_i (.ref_clk(ref_clk), .busGrant(busGrant),
    .dtackOeN(dtackOeN), .berrOeN(berrOeN), .rdata(dataBus), .bbsyN(bbsyN), .asN(asN),
    .ds0N(ds0N), .ds1N(ds1N), .writeN(writeN), .lwordN(lwordN), .addr(addr), .wdata(wdata));
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // One transfer against the byte-lane model; m makes it miss the window.
  task automatic op(input int k, input bit a, input bit w, input int idx, input bit m,
                    input bit ovl);
    logic [31:0] d, exp, got;
    int rsp, b;
    bit s;
    d = $urandom;
    exp = '0;
    for (b = 0; b < 4; b++) begin
      s = !m && (k == 3 || (k < 3 && b / 2 == a && (k == 2 || b % 2 == k)));
      if (s && w) mem[idx][8*(3-b)+:8] = d[8*(k == 3 ? 3-b : 1-b%2)+:8];
      if (s && !w) exp[8*(k == 3 ? 3-b : 1-b%2)+:8] = mem[idx][8*(3-b)+:8];
    end
    am <= 6'($urandom);
    dts_master_model_i.cyc({m, 21'h0, 8'(idx), a}, k, w, d, ovl, rsp, got);
    chk(rsp == (m || k == 5 ? 0 : k == 4 ? 2 : 1), "response");
    // A wait that ran out ends the run at once.
    if (rsp == 3) test_done;
    if (!w && rsp == 1) chk(got === exp, "read data");
    if (!m && k < 4) ackCnt++;
    chk(pulseCnt == ackCnt, "access count");
    if (!m && k < 4) chk(accessWrite === w, "access direction");
  endtask
  task automatic handover;
    dts_master_model_i.release_bus;
    @(posedge ref_clk);
    busGrant <= 1'b0;
    fork
      op(2, 0, 0, 1, 0, 0);
      begin
        repeat (12) @(posedge ref_clk);
        chk(asN === 1'b1 && bbsyN === 1'b1, "strobe without grant");
        busGrant <= 1'b1;
      end
    join
  endtask
  task automatic test_done;
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    int k;
    void'($urandom(32'h544b));
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) op(3, 0, 1, i, 0, 0);
    for (int i = 0; i < 60; i++) begin
      k = $urandom % 6;
      op(k, k == 4 || (k < 3 && $urandom % 2), $urandom % 2, $urandom % 4,
         $urandom % 8 == 0, $urandom % 2);
      if (i % 15 == 14) handover;
    end
    test_done;
  end
endmodule
`default_nettype wire

// file: hdl/dts_pkg.sv
// Constants shared by the data-transfer-bus slave with address overlap tolerance.
package dts_pkg;

  // Clock period of ref_clk in picoseconds.
  localparam int CLK_PERIOD_PS = 4000;

  // Time allowed for the second data strobe to follow the first, in nanoseconds.
  localparam int STROBE_SKEW_NS = 20;

  // Skew time as whole clock cycles, rounded up, never below one.
  localparam int STROBE_SKEW_CYC_RAW = (STROBE_SKEW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_SKEW_CYC = (STROBE_SKEW_CYC_RAW < 1) ? 1 : STROBE_SKEW_CYC_RAW;

  // Width of the skew counter.
  localparam int SKEW_CNT_W = 4;

  // Bus widths.
  localparam int ADDR_W = 31;
  localparam int AM_W   = 6;
  localparam int DATA_W = 32;

  // Bit position of the lowest byte-select address line within the address port.
  localparam int A01_POS = 0;

  // Bus bit positions of the two byte lanes used by single and double transfers.
  localparam int EVEN_LANE_LSB = 8;
  localparam int ODD_LANE_LSB  = 0;

  // Reset value of the data output register.
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  // Slave sequencer states.
  typedef enum logic [1:0] {
    DTS_IDLE   = 2'b00,
    DTS_SETTLE = 2'b01,
    DTS_ACK    = 2'b10
  } dts_state_t;

endpackage

// file: hdl/dts_slave.sv
// Data-transfer-bus slave with memory, overlap tolerance and byte-lane decode.
`timescale 1ns/10ps
`default_nettype none
module dts_slave #(
  parameter int                       MEM_IDX_W = 8,            // Word index width of memory.
  parameter logic [dts_pkg::ADDR_W-1:0] BASE    = 31'h0000_0000 // Base address, word aligned.
) (
  input  wire logic                         ref_clk,     // System clock.
  input  wire logic                         rstn,        // Asynchronous reset, active low.
  input  wire logic [dts_pkg::ADDR_W-1:0]   addrIn,      // Address lines A01 upward.
  input  wire logic [dts_pkg::AM_W-1:0]     amIn,        // Address modifier lines.
  input  wire logic                         lwordN,      // Long word select, active low.
  input  wire logic                         iackN,       // Interrupt acknowledge, active low.
  input  wire logic                         asN,         // Address strobe, active low.
  input  wire logic                         ds0N,        // Data strobe zero, active low.
  input  wire logic                         ds1N,        // Data strobe one, active low.
  input  wire logic                         writeN,      // Write direction, active low.
  input  wire logic [dts_pkg::DATA_W-1:0]   dataIn,      // Data lines as seen on the bus.
  output logic      [dts_pkg::DATA_W-1:0]   dataOut,     // Data driven onto the bus.
  output logic                              dataOeN,     // Data drive enable, low drives.
  output logic                              dtackOut,    // Acknowledge level when driven.
  output logic                              dtackOeN,    // Acknowledge drive enable, low drives.
  output logic                              berrOut,     // Bus error level when driven.
  output logic                              berrOeN,     // Bus error drive enable, low drives.
  output logic                              accessPulse, // One cycle per completed transfer.
  output logic                              accessWrite  // Direction of the last transfer.
);

  // Reset synchroniser: first stage feeds only the second.
  logic rstMeta;
  logic rstSync;

  // Memory that backs the slave, one 32-bit word per index.
  logic [dts_pkg::DATA_W-1:0] mem [0:(1<<MEM_IDX_W)-1];

  // Addressing captured on the address strobe falling edge.
  logic [dts_pkg::ADDR_W-1:0] latAddr;  // Latched address.
  logic                       latLword; // Latched long word select.
  logic                       latHit;   // Latched cycle is for this slave.

  // Working copy held for the data transfer in progress.
  logic [dts_pkg::ADDR_W-1:0] workAddr;
  logic                       workLword;

  // Previous samples for edge detection.
  logic asPrevN;
  logic dsAnyPrevN;

  // Sequencer state and skew counter.
  dts_pkg::dts_state_t state;
  logic [dts_pkg::SKEW_CNT_W-1:0] skewCnt;

  // Derived strobe terms.
  logic dsAnyN;
  logic asFall;
  logic dsFall;
  logic dsBothHigh;
  logic addrHit;

  // Lane decode results.
  logic [3:0] laneMask;
  logic       quadMode;
  logic       laneBad;

  // Strobe edges come from plain synchronous samples of the pins.
  assign dsAnyN     = ds0N & ds1N;
  assign asFall     = asPrevN & ~asN;
  assign dsFall     = dsAnyPrevN & ~dsAnyN;
  assign dsBothHigh = ds0N & ds1N;
  assign addrHit    = (addrIn[dts_pkg::ADDR_W-1:MEM_IDX_W+1] == BASE[dts_pkg::ADDR_W-1:MEM_IDX_W+1]);

  // Release of reset through two flip-flops.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Previous strobe levels; idle bus reads high.
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      asPrevN    <= 1'b1;
      dsAnyPrevN <= 1'b1;
    end else begin
      asPrevN    <= asN;
      dsAnyPrevN <= dsAnyN;
    end
  end

  // latch on address fall.
  // A new address strobe during an open transfer only refreshes this latch,
  // so the working copy of the running transfer is never disturbed.
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      latAddr  <= '0;
      latLword <= 1'b1;
      latHit   <= 1'b0;
    end else if (asFall) begin
      latAddr  <= addrIn;
      latLword <= lwordN;
      // An interrupt acknowledge cycle is never a memory access.
      latHit   <= addrHit & iackN;
    end
  end

  // Byte lane decode from strobes, low address bit and long word select.
  always_comb begin
    laneMask = 4'b0000;
    quadMode = 1'b0;
    laneBad  = 1'b0;
    unique case ({ds1N, ds0N})
      2'b01: begin
        laneMask = workAddr[dts_pkg::A01_POS] ? 4'b0100 : 4'b0001;
      end
      2'b10: begin
        laneMask = workAddr[dts_pkg::A01_POS] ? 4'b1000 : 4'b0010;
      end
      // Both strobes: double or quad transfer.
      2'b00: begin
        if (!workLword) begin
          quadMode = 1'b1;
          laneMask = 4'b1111;
          laneBad  = workAddr[dts_pkg::A01_POS];
        end else begin
          laneMask = workAddr[dts_pkg::A01_POS] ? 4'b1100 : 4'b0011;
        end
      end
      // No strobe left low: nothing to move.
      2'b11: begin
        laneBad = 1'b1;
      end
    endcase
  end

  // Transfer sequencer.
  // start on strobe fall.
  // address-only cycles never reach the data path.
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      state     <= dts_pkg::DTS_IDLE;
      skewCnt   <= '0;
      workAddr  <= '0;
      workLword <= 1'b1;
    end else begin
      unique case (state)
        // Wait for the first data strobe of a cycle addressed to us.
        dts_pkg::DTS_IDLE: begin
          if (dsFall && latHit) begin
            workAddr  <= latAddr;
            workLword <= latLword;
            skewCnt   <= dts_pkg::SKEW_CNT_W'(dts_pkg::STROBE_SKEW_CYC);
            state     <= dts_pkg::DTS_SETTLE;
          end
        end
        // allow strobe skew.
        // The second strobe may follow late; lanes are judged only afterwards.
        dts_pkg::DTS_SETTLE: begin
          if (skewCnt > dts_pkg::SKEW_CNT_W'(1)) begin
            skewCnt <= skewCnt - dts_pkg::SKEW_CNT_W'(1);
          end else begin
            state <= dts_pkg::DTS_ACK;
          end
        end
        // end on both high.
        // Release waits for both strobes, whichever rises first.
        dts_pkg::DTS_ACK: begin
          if (dsBothHigh) begin
            state <= dts_pkg::DTS_IDLE;
          end
        end
        default: begin
          state <= dts_pkg::DTS_IDLE;
        end
      endcase
    end
  end

  // Memory write at the end of the skew window.
  always_ff @(posedge ref_clk) begin
    if (state == dts_pkg::DTS_SETTLE && skewCnt <= dts_pkg::SKEW_CNT_W'(1)
        && !laneBad && !writeN) begin
      for (int k = 0; k < 4; k++) begin
        if (laneMask[k]) begin
          if (quadMode) begin
            mem[workAddr[MEM_IDX_W:1]][31-8*k -: 8] <= dataIn[31-8*k -: 8];
          end else if (k % 2 == 0) begin
            mem[workAddr[MEM_IDX_W:1]][31-8*k -: 8] <= dataIn[dts_pkg::EVEN_LANE_LSB +: 8];
          end else begin
            mem[workAddr[MEM_IDX_W:1]][31-8*k -: 8] <= dataIn[dts_pkg::ODD_LANE_LSB +: 8];
          end
        end
      end
    end
  end

  // overlap tolerated.
  // Bus drivers and acknowledges follow only the working transfer, so a new
  // address strobe while a data strobe is still low changes none of them.
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      dataOut     <= dts_pkg::DATA_RST;
      dataOeN     <= 1'b1;
      dtackOut    <= 1'b1;
      dtackOeN    <= 1'b1;
      berrOut     <= 1'b1;
      berrOeN     <= 1'b1;
      accessPulse <= 1'b0;
      accessWrite <= 1'b0;
    end else begin
      accessPulse <= 1'b0;
      if (state == dts_pkg::DTS_SETTLE && skewCnt <= dts_pkg::SKEW_CNT_W'(1)) begin
        if (laneBad) begin
          // Lane pattern this slave cannot serve: answer with bus error.
          berrOut <= 1'b0;
          berrOeN <= 1'b0;
        end else begin
          // Good lanes: acknowledge, and for a read drive the selected bytes.
          dtackOut    <= 1'b0;
          dtackOeN    <= 1'b0;
          accessPulse <= 1'b1;
          accessWrite <= ~writeN;
          if (writeN) begin
            dataOeN <= 1'b0;
            dataOut <= dts_pkg::DATA_RST;
            for (int k = 0; k < 4; k++) begin
              if (laneMask[k]) begin
                if (quadMode) begin
                  dataOut[31-8*k -: 8] <= mem[workAddr[MEM_IDX_W:1]][31-8*k -: 8];
                end else if (k % 2 == 0) begin
                  dataOut[dts_pkg::EVEN_LANE_LSB +: 8] <= mem[workAddr[MEM_IDX_W:1]][31-8*k -: 8];
                end else begin
                  dataOut[dts_pkg::ODD_LANE_LSB +: 8] <= mem[workAddr[MEM_IDX_W:1]][31-8*k -: 8];
                end
              end
            end
          end
        end
      end else if (state == dts_pkg::DTS_ACK && dsBothHigh) begin
        // Both strobes high: release data, acknowledge and error lines.
        dataOeN  <= 1'b1;
        dtackOut <= 1'b1;
        dtackOeN <= 1'b1;
        berrOut  <= 1'b1;
        berrOeN  <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire
